//--- verilog/ast_pkg.sv
package ast_pkg;
	// ----------------------------------------------------------------
	// register map and fields
	// ----------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [2:0] REG_STATUS = 3'h0;
	localparam logic [2:0] REG_DATA = 3'h1;
	localparam logic [2:0] REG_CTRL1 = 3'h2;
	localparam logic [2:0] REG_CTRL2 = 3'h3;
	localparam logic [2:0] REG_TXDIV_LO = 3'h4;
	localparam logic [2:0] REG_TXDIV_HI = 3'h5;
	localparam logic [2:0] REG_RXDIV_LO = 3'h6;
	localparam logic [2:0] REG_RXDIV_HI = 3'h7;
	localparam int ST_TX_BUF_EMPTY_FLAG = 7;
	localparam int ST_TC = 6;
	localparam int ST_LINE = 0;
	localparam int CR1_T8 = 6;
	localparam int CR1_M = 4;
	localparam int CR2_TIE = 7;
	localparam int CR2_TX_COMPLETE_IRQ_EN = 6;
	localparam int CR2_TE = 3;
	localparam int CR2_RE = 2;
	localparam int CR2_SBK = 0;
	localparam logic [7:0] CR1_RESET = 8'h00;
	localparam logic [7:0] CR2_RESET = 8'h00;
	// ----------------------------------------------------------------
	// frame format and timing
	// ----------------------------------------------------------------
	localparam int FRAME_W = 11;
	localparam int LEN_W = 4;
	localparam logic [3:0] LEN_W8 = 4'hA;
	localparam logic [3:0] LEN_W9 = 4'hB;
	localparam logic [3:0] LEN_MARK = 4'h1;
	localparam int DIV_W = 16;
	localparam int CLK_HZ = 125_000_000;
	localparam int DEF_BAUD = 9600;
	localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / DEF_BAUD);
	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_IDLE,
		KIND_BREAK,
		KIND_MARK,
		KIND_DATA
	} ast_kind_t;
endpackage : ast_pkg

//--- verilog/ast_shift_if.sv
interface ast_shift_if;
	import ast_pkg::*;
	logic load;
	logic [FRAME_W-1:0] frame;
	logic [LEN_W-1:0] len;
	logic tick;
	logic busy;
	logic last;
	logic bit_out;
	modport ctl(output load, frame, len, tick, input busy, last, bit_out);
	modport eng(input load, frame, len, tick, output busy, last, bit_out);
endinterface : ast_shift_if

//--- verilog/ast_baud.sv
module ast_baud #(
	parameter int DW = ast_pkg::DIV_W
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic en,
	input wire logic restart,
	input wire logic [DW-1:0] div,
	output logic tick
);
	import ast_pkg::*;
	logic [DW-1:0] cnt_q;
	wire [DW-1:0] div_m1 = (div == '0) ? '0 : div - DW'(1);
	wire wrap = cnt_q >= div_m1;

	if (DW < 2) begin : g_chk
		$error("ast_baud: divisor width too small");
	end

	// counter restarts with each frame so the first bit is a full period
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= (restart || !en || wrap) ? '0 : cnt_q + DW'(1);
		end
	end
	// tick decoded from the count, not registered: a registered tick would
	// stretch every first bit by one cycle; restart is left out to avoid a loop
	// through the load path, the shifter ignores a tick in its load cycle anyway
	assign tick = en && wrap;
endmodule : ast_baud

//--- verilog/ast_shift.sv
module ast_shift (
	input wire logic core_clk,
	input wire logic sys_rst,
	ast_shift_if.eng sif
);
	import ast_pkg::*;
	logic [FRAME_W-1:0] sh_q;
	logic [LEN_W-1:0] cnt_q;
	logic busy_q;

	// ----------------------------------------------------------------
	// bit shifter
	// ----------------------------------------------------------------
	assign sif.last = busy_q && sif.tick && (cnt_q == LEN_W'(1));
	assign sif.busy = busy_q;
	assign sif.bit_out = sh_q[0];

	// a load wins over the last tick so frames follow with no gap
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sh_q <= '1;
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else if (sif.load) begin
			sh_q <= sif.frame;
			cnt_q <= sif.len;
			busy_q <= 1'b1;
		end else if (busy_q && sif.tick) begin
			sh_q <= {1'b1, sh_q[FRAME_W-1:1]}; // [R10] [R21]
			cnt_q <= cnt_q - LEN_W'(1);
			busy_q <= cnt_q != LEN_W'(1);
		end
	end

	shift_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		busy_q && sif.tick && !sif.load && cnt_q > LEN_W'(1)
		|=> sh_q[0] == $past(sh_q[1]) && cnt_q == $past(cnt_q) - LEN_W'(1)) // [R21]
		else $error("shifter did not advance one bit per tick");
	frame_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		sif.load |=> busy_q && cnt_q == $past(sif.len)) // [R03]
		else $error("frame length not taken on load");
endmodule : ast_shift

//--- verilog/ast_top.sv
// Operation
// (R01) Enabled and not sending, the transmit pin stays high.
// (R02) Both directions disabled, the transmit pin is released to the port.
// (R03) Frame: start bit, 8 or 9 data bits LSB first, stop bit.
// (R04) Start bit drives the transmit pin low.
// (R05) Stop bit drives the transmit pin high.
// (R06) Idle character is a whole frame of ones.
// (R07) Break is zero frames, then one extra high bit.
// (R08) Transmit and receive each have their own baud generator.
// (R09) Word length bit picks 8 or 9 bits; ninth bit from ctrl.
// (R10) Data shifts out LSB first through a buffer then shift register.
// (R11) Setting transmit enable takes the pin and sends an idle frame first.
// (R12) Buffer-empty clears only on status read then data write.
// (R13) Buffer-empty sets when the buffer moves into the shift register.
// (R14) Buffer-empty interrupts when enabled and the CPU mask is clear.
// (R15) Write during a frame waits in the buffer until frame end.
// (R16) Write while idle loads the shifter at once and sets buffer-empty.
// (R17) After a stop bit, complete flag sets and may interrupt; here only after a data frame's stop bit.
// (R18) Complete flag clears by the same read then write sequence.
// (R19) Break frames repeat while break bit stays set, then one high bit.
// (R20) Enable cleared then set mid frame queues an idle frame after it.
// (R21) One bit goes out per transmit baud period.
//
// Our own choices: the address-and-strobe port and the register addresses.
module ast_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [ast_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ast_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ast_pkg::DATA_W-1:0] reg_rdata,
	input wire logic cpu_irq_mask,
	input wire logic rx_in_pin,
	output logic tx_out,
	output logic tx_oe,
	output logic irq
);
	import ast_pkg::*;

	ast_shift_if sif();

	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [DIV_W-1:0] txdiv_q;
	logic [DIV_W-1:0] rxdiv_q;
	logic [7:0] buf_q;
	logic buf_full_q;
	logic tx_buf_empty_flag_q;
	logic tc_q;
	logic armed_q;
	logic idle_pend_q;
	logic brk_tail_q;
	logic te_prev_q;
	logic line_q;
	ast_kind_t kind_q;
	logic tx_out_q;
	logic tx_oe_q;
	logic irq_q;
	logic [7:0] rdata_q;
	logic rx_tick;

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	wire sel_status = reg_addr == REG_STATUS;
	wire sel_data = reg_addr == REG_DATA;
	wire wr_data = reg_wr && sel_data;
	wire rd_status = reg_rd && sel_status;
	wire te = ctrl2_q[CR2_TE];
	wire re = ctrl2_q[CR2_RE];
	wire send_break_bit = ctrl2_q[CR2_SBK];
	wire word9 = ctrl1_q[CR1_M];
	wire [7:0] status_val = {tx_buf_empty_flag_q, tc_q, 5'h00, line_q};
	logic [7:0] rd_val;
	always_comb begin
		if (sel_status) begin
			rd_val = status_val;
		end else if (sel_data) begin
			rd_val = buf_q;
		end else if (reg_addr == REG_CTRL1) begin
			rd_val = ctrl1_q;
		end else if (reg_addr == REG_CTRL2) begin
			rd_val = ctrl2_q;
		end else if (reg_addr == REG_TXDIV_LO) begin
			rd_val = txdiv_q[7:0];
		end else if (reg_addr == REG_TXDIV_HI) begin
			rd_val = txdiv_q[15:8];
		end else if (reg_addr == REG_RXDIV_LO) begin
			rd_val = rxdiv_q[7:0];
		end else begin
			rd_val = rxdiv_q[15:8];
		end
	end

	// ----------------------------------------------------------------
	// frame selection
	// ----------------------------------------------------------------
	// priority: queued idle, break, tail mark, buffered word, direct write
	wire eng_free = !sif.busy || sif.last;
	wire want_idle = te && idle_pend_q; // [R11] [R20]
	wire want_brk = te && !idle_pend_q && send_break_bit; // [R19]
	wire want_mark = te && !idle_pend_q && !send_break_bit && brk_tail_q; // [R07]
	wire want_buf = te && !idle_pend_q && !send_break_bit && !brk_tail_q && buf_full_q; // [R15]
	wire want_dir = te && !idle_pend_q && !send_break_bit && !brk_tail_q && !buf_full_q && wr_data;
	wire do_load = eng_free && (want_idle || want_brk || want_mark || want_buf || want_dir);
	wire ld_dir = eng_free && want_dir; // [R16]
	wire ld_data = eng_free && (want_buf || want_dir);
	wire [7:0] word = want_buf ? buf_q : reg_wdata;
	wire ninth = word9 ? ctrl1_q[CR1_T8] : 1'b1; // [R09]
	wire [FRAME_W-1:0] data_frame = {1'b1, ninth, word, 1'b0}; // [R03] [R04] [R05]
	wire [LEN_W-1:0] frame_len = word9 ? LEN_W9 : LEN_W8;
	wire clr_seq = wr_data && armed_q; // [R12] [R18]

	assign sif.load = do_load;
	assign sif.frame = want_idle ? '1 : (want_brk ? '0 : (want_mark ? '1 : data_frame)); // [R06]
	assign sif.len = want_mark ? LEN_MARK : frame_len;

	// ----------------------------------------------------------------
	// baud generators and shifter
	// ----------------------------------------------------------------
	// separate dividers so each direction runs at its own rate
	ast_baud #(.DW(DIV_W)) u_tx_baud ( // [R08]
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.en(sif.busy),
		.restart(do_load),
		.div(txdiv_q),
		.tick(sif.tick)
	);
	ast_baud #(.DW(DIV_W)) u_rx_baud ( // [R08]
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.en(re),
		.restart(1'b0),
		.div(rxdiv_q),
		.tick(rx_tick)
	);
	ast_shift u_shift (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.sif(sif.eng)
	);

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl1_q <= CR1_RESET;
			ctrl2_q <= CR2_RESET;
			txdiv_q <= DIV_RESET;
			rxdiv_q <= DIV_RESET;
			rdata_q <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == REG_CTRL1) ctrl1_q <= reg_wdata;
			if (reg_wr && reg_addr == REG_CTRL2) ctrl2_q <= reg_wdata;
			if (reg_wr && reg_addr == REG_TXDIV_LO) txdiv_q[7:0] <= reg_wdata;
			if (reg_wr && reg_addr == REG_TXDIV_HI) txdiv_q[15:8] <= reg_wdata;
			if (reg_wr && reg_addr == REG_RXDIV_LO) rxdiv_q[7:0] <= reg_wdata;
			if (reg_wr && reg_addr == REG_RXDIV_HI) rxdiv_q[15:8] <= reg_wdata;
			rdata_q <= reg_rd ? rd_val : 8'h00;
		end
	end

	// transmit buffer; dropping the enable discards a waiting word
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			buf_q <= 8'h00;
			buf_full_q <= 1'b0;
		end else begin
			if (wr_data && !ld_dir) buf_q <= reg_wdata; // [R15]
			if (!te) buf_full_q <= 1'b0;
			else if (wr_data && !ld_dir) buf_full_q <= 1'b1;
			else if (eng_free && want_buf) buf_full_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// flags and sequencing
	// ----------------------------------------------------------------
	// a hardware set in the clearing cycle wins over the clear
	wire tc_set = sif.last && kind_q == KIND_DATA; // [R17]
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_buf_empty_flag_q <= 1'b1;
			tc_q <= 1'b1;
			armed_q <= 1'b0;
		end else begin
			tx_buf_empty_flag_q <= ld_data || !te || (tx_buf_empty_flag_q && !clr_seq); // [R13] [R16] [R12]
			tc_q <= tc_set || (tc_q && !clr_seq); // [R17] [R18]
			armed_q <= rd_status || (armed_q && !wr_data);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			idle_pend_q <= 1'b0;
			brk_tail_q <= 1'b0;
			te_prev_q <= 1'b0;
			kind_q <= KIND_NONE;
		end else begin
			te_prev_q <= te;
			idle_pend_q <= (te && !te_prev_q) || (idle_pend_q && !(eng_free && want_idle)); // [R11] [R20]
			if (eng_free && want_brk) brk_tail_q <= 1'b1; // [R19]
			else if (eng_free && want_mark) brk_tail_q <= 1'b0; // [R07]
			if (do_load) begin
				kind_q <= want_idle ? KIND_IDLE : (want_brk ? KIND_BREAK :
					(want_mark ? KIND_MARK : KIND_DATA));
			end else if (sif.last) begin
				kind_q <= KIND_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// pins and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_out_q <= 1'b1;
			tx_oe_q <= 1'b0;
			irq_q <= 1'b0;
			line_q <= 1'b1;
		end else begin
			tx_out_q <= sif.busy ? sif.bit_out : 1'b1; // [R01] [R04] [R05]
			tx_oe_q <= te || re; // [R02] [R11]
			irq_q <= !cpu_irq_mask && ((tx_buf_empty_flag_q && ctrl2_q[CR2_TIE]) ||
				(tc_q && ctrl2_q[CR2_TX_COMPLETE_IRQ_EN])); // [R14] [R17]
			if (rx_tick) line_q <= rx_in_pin;
		end
	end

	assign tx_out = tx_out_q;
	assign tx_oe = tx_oe_q;
	assign irq = irq_q;
	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_armed_write;
		armed_q && wr_data && !ld_data && te;
	endsequence

	idle_high_a: assert property (tx_oe_q && !sif.busy && !$past(sif.busy) |=> tx_out_q) // [R01]
		else $error("transmit pin not high while idle");
	pin_release_a: assert property (!te && !re |=> !tx_oe_q) // [R02]
		else $error("transmit pin not released");
	start_low_a: assert property (ld_data |-> ##2 !tx_out_q) // [R04]
		else $error("start bit not low");
	flag_clear_a: assert property (s_armed_write |=> !tx_buf_empty_flag_q) // [R12]
		else $error("buffer-empty not cleared by sequence");
	empty_set_a: assert property (ld_data |=> tx_buf_empty_flag_q && !buf_full_q) // [R13]
		else $error("buffer-empty not set on transfer");
	empty_irq_a: assert property (tx_buf_empty_flag_q && ctrl2_q[CR2_TIE] && !cpu_irq_mask |=> irq_q) // [R14]
		else $error("buffer-empty interrupt missing");
	direct_load_a: assert property (wr_data && te && !sif.busy && !buf_full_q &&
		!idle_pend_q && !send_break_bit && !brk_tail_q |-> sif.load ##1 tx_buf_empty_flag_q) // [R16]
		else $error("idle write did not start frame");
	complete_set_a: assert property (tc_set |=> tc_q) // [R17]
		else $error("complete flag not set after stop bit");
	idle_queue_a: assert property (te && !te_prev_q |=> idle_pend_q || kind_q == KIND_IDLE) // [R20]
		else $error("idle frame not queued on enable");
	break_tail_a: assert property (sif.last && kind_q == KIND_BREAK && !send_break_bit && te &&
		!idle_pend_q |-> sif.load && sif.len == LEN_MARK) // [R07]
		else $error("break not followed by one high bit");
endmodule : ast_top

//--- dv/ast_far_rx.sv
// ------------------------------------------------------------
// far-side receiver model
// ------------------------------------------------------------
module ast_far_rx #(
	parameter int DIV = 4
) (
	input wire logic core_clk,
	input wire logic line,
	input wire logic oe,
	input wire logic nine,
	output logic [8:0] word,
	output logic stop,
	output logic [7:0] seq,
	output logic rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] w;
	logic more;
	// our own transmitter stays silent at mark level
	assign rx_line = 1'b1;
	initial begin
		seq = 8'h00;
		word = '0;
		stop = 1'b1;
	end
	// sample mid-bit; a low stop with the line still low means the break run goes on
	always begin
		@(posedge core_clk);
		if (oe && !line) begin
			repeat (DIV / 2) @(posedge core_clk);
			more = 1'b1;
			while (more) begin
				w = '0;
				for (int i = 0; i < 9; i++) begin
					if (i < 8 || nine) begin
						repeat (DIV) @(posedge core_clk);
						w[i] = line;
					end
				end
				repeat (DIV) @(posedge core_clk);
				word <= w;
				stop <= line;
				seq <= seq + 8'h01;
				more = 1'b0;
				if (!line) begin
					repeat (DIV) @(posedge core_clk);
					more = !line;
				end
			end
		end
	end
endmodule : ast_far_rx

//--- dv/async_serial_transmitter_bench.sv
module async_serial_transmitter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ast_pkg::*;
	localparam int DIV = 4;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cpu_irq_mask = 1'b0;
	logic nine = 1'b0;
	logic t8 = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic tx_out;
	logic tx_oe;
	logic irq;
	logic rx_line;
	logic stop;
	logic [8:0] word;
	logic [7:0] seq;
	logic [7:0] seen_seq = 8'h00;
	logic [9:0] exp_q[$];
	logic [7:0] v;
	int k;
	int miscompares = 0;
	int n_checks = 0;

	always #4 core_clk = ~core_clk;

	ast_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_irq_mask(cpu_irq_mask), .rx_in_pin(rx_line), .tx_out(tx_out), .tx_oe(tx_oe),
		.irq(irq));
	ast_far_rx #(.DIV(DIV)) far_u (.core_clk(core_clk), .line(tx_out), .oe(tx_oe),
		.nine(nine), .word(word), .stop(stop), .seq(seq), .rx_line(rx_line));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd

	// arm=0 skips the status read, so the flags must not clear
	task automatic send(input logic [7:0] b, input logic arm);
		if (arm) rd(REG_STATUS, v);
		wr(REG_DATA, b);
		exp_q.push_back({1'b1, nine & t8, b});
	endtask : send

	task automatic drain;
		for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge core_clk);
		repeat (8) @(posedge core_clk);
		check("pending", 16'(exp_q.size()), 16'h0000);
		rd(REG_STATUS, v);
		check("status", {8'h00, v}, 16'h00C1);
	endtask : drain

	task automatic wrap_up;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// oldest note is compared whenever the far side finishes a frame
	always @(posedge core_clk) begin
		if (seq !== seen_seq) begin
			seen_seq = seq;
			check("frame", {6'h00, stop, word}, {6'h00, (exp_q.size() > 0) ? exp_q.pop_front() : 10'hX});
		end
	end

	// cuts a hang short; the whole run is under a thousand cycles
	initial begin
		repeat (30000) @(posedge core_clk);
		miscompares++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h5cb450e8));
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(REG_STATUS, v);
		check("status", {8'h00, v}, 16'h00C1);
		check("oe", {15'h0000, tx_oe}, 16'h0000);
		$display("test reset done");
		wr(REG_TXDIV_LO, 8'(DIV));
		wr(REG_TXDIV_HI, 8'h00);
		wr(REG_RXDIV_LO, 8'(DIV));
		wr(REG_RXDIV_HI, 8'h00);
		wr(REG_CTRL2, 8'(1 << CR2_TE));
		k = 0;
		repeat (44) begin
			@(negedge core_clk);
			k += int'(tx_out);
		end
		check("idle", 16'(k), 16'(44));
		check("oe", {15'h0000, tx_oe}, 16'h0001);
		$display("test enable done");
		// second write lands in the buffer; the last round leaves the second write unarmed
		for (int r = 0; r < 3; r++) begin
			send(8'($urandom), 1'b1);
			send(8'($urandom), r != 2);
			rd(REG_STATUS, v);
			check("status", {8'h00, v}, (r == 2) ? 16'h0081 : 16'h0001);
			drain();
		end
		$display("test data done");
		nine = 1'b1;
		for (int t = 0; t < 2; t++) begin
			t8 = t[0];
			wr(REG_CTRL1, 8'(1 << CR1_M) | 8'(t << CR1_T8));
			send(8'($urandom), 1'b1);
			drain();
		end
		wr(REG_CTRL1, 8'h00);
		nine = 1'b0;
		$display("test ninth done");
		// three break frames, then the mark bit lets the next start show
		wr(REG_CTRL2, 8'(1 << CR2_TE) | 8'(1 << CR2_SBK));
		repeat (3) exp_q.push_back(10'h000);
		repeat (100) @(posedge core_clk);
		wr(REG_CTRL2, 8'(1 << CR2_TE));
		send(8'($urandom), 1'b1);
		drain();
		$display("test break done");
		wr(REG_CTRL2, 8'(1 << CR2_TE) | 8'(1 << CR2_TIE));
		repeat (3) @(negedge core_clk);
		check("irq", {15'h0000, irq}, 16'h0001);
		@(posedge core_clk);
		cpu_irq_mask <= 1'b1;
		repeat (3) @(negedge core_clk);
		check("irq", {15'h0000, irq}, 16'h0000);
		@(posedge core_clk);
		cpu_irq_mask <= 1'b0;
		wr(REG_CTRL2, 8'(1 << CR2_TE) | 8'(1 << CR2_TX_COMPLETE_IRQ_EN));
		repeat (3) @(negedge core_clk);
		check("irq", {15'h0000, irq}, 16'h0001);
		$display("test irq done");
		wr(REG_CTRL2, 8'(1 << CR2_RE));
		repeat (3) @(negedge core_clk);
		check("line", {14'h0000, tx_oe, tx_out}, 16'h0003);
		wr(REG_CTRL2, 8'h00);
		repeat (3) @(negedge core_clk);
		check("oe", {15'h0000, tx_oe}, 16'h0000);
		$display("test release done");
		wrap_up();
	end
endmodule : async_serial_transmitter_bench
